// [irq_pkg.sv]
/*
  Constants, field positions and carrier types shared by the interrupt
  controller and its low-voltage source. Assumes one 50 MHz system clock
  and a simple strobed register port driven by the CPU core.
*/
package irq_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int REG_ADDR_W = 4;
  localparam int REG_COUNT = 8;
  localparam logic [3:0] IDX_EDGE = 4'h0;
  localparam logic [3:0] IDX_CTRL_A = 4'h1;
  localparam logic [3:0] IDX_CTRL_B = 4'h2;
  localparam logic [3:0] IDX_CTRL_C = 4'h3;
  localparam logic [3:0] IDX_GRP_A = 4'h4;
  localparam logic [3:0] IDX_GRP_B = 4'h5;
  localparam logic [3:0] IDX_GRP_C = 4'h6;
  localparam logic [3:0] IDX_LVD = 4'h7;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Implemented bits per register, index 7 down to 0.
  localparam logic [7:0][7:0] IMPL_MASK = {8'h37, 8'h33, 8'h33, 8'h33,
                                           8'hFF, 8'hFF, 8'h5B, 8'h0F};

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EDGE_FIELD_W = 2;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  localparam int CA_MF0_FLAG = 6;
  localparam int CA_PA_FLAG = 4;
  localparam int CA_MF0_EN = 3;
  localparam int CA_PA_EN = 1;
  localparam int CA_GLOBAL_EN = 0;
  localparam int CB_TB0 = 7;
  localparam int CB_ADC = 6;
  localparam int CB_MF2 = 5;
  localparam int CB_MF1 = 4;
  localparam int CC_UART = 7;
  localparam int CC_SIM = 6;
  localparam int CC_PB = 5;
  localparam int CC_TB1 = 4;
  localparam int CC_UART_EN = 3;
  localparam int PAIR_FLAG_HI = 7;
  localparam int PAIR_FLAG_LO = 4;
  localparam int PAIR_EN_HI = 3;
  localparam int PAIR_EN_LO = 0;
  localparam int GRP_FLAG_HI = 5;
  localparam int GRP_FLAG_LO = 4;
  localparam int GRP_EN_HI = 1;
  localparam int GRP_EN_LO = 0;
  localparam int GRP_MATCH_A = 5;
  localparam int GRP_MATCH_P = 4;
  localparam int GC_EEPROM = 5;
  localparam int GC_LV = 4;
  localparam int LVD_STATUS = 5;
  localparam int LVD_ON = 4;
  localparam int LVD_THR_HI = 2;
  localparam int LVD_THR_LO = 0;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int LV_DELAY_NS = 15000;
  localparam int LV_DELAY_CYC = (LV_DELAY_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LV_WAIT = 2'b00,
    LV_COUNT = 2'b01,
    LV_FIRED = 2'b10
  } lv_delay_state_t;

  // One-cycle event pulses from the peripheral sources.
  typedef struct packed {
    logic tm0_match_a;
    logic tm0_match_p;
    logic tm1_match_a;
    logic tm1_match_p;
    logic eeprom_done;
    logic time_base0;
    logic time_base1;
    logic adc_done;
    logic sim_event;
    logic uart_event;
  } periph_evt_t;

endpackage : irq_pkg

// [pin_edge_detect.sv]
/*
  Edge detector for one external interrupt pin with selectable edge.
  Assumes the pin is already synchronous to clk_i.
*/
`timescale 1ns/10ps
module pin_edge_detect (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Pin and edge field
  input wire logic pin_i,
  input wire logic [1:0] edge_sel_i,
  // Qualified edge
  output logic hit_o
);

  typedef struct packed {
    logic prev;
  } edge_state_t;

  edge_state_t st_reg;
  edge_state_t st_next;

  // Remember the last pin level so edges can be seen.
  always_comb begin
    st_next = st_reg;
    st_next.prev = pin_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Code 00 selects no edge, so a disabled pin never hits.
  assign hit_o = (pin_i & ~st_reg.prev & edge_sel_i[irq_pkg::EDGE_RISE_BIT])
    | (~pin_i & st_reg.prev & edge_sel_i[irq_pkg::EDGE_FALL_BIT]);

  edge_decode_a: assert property (@(posedge clk_i) disable iff (reset_i)
    hit_o |-> (edge_sel_i != 2'h0) && (pin_i != st_reg.prev))
    else $error("Edge hit with pin disabled or no transition.");

endmodule : pin_edge_detect

// [lowvolt_delay.sv]
/*
  Delays the rise of the supply-low status into a single request pulse.
  Assumes the status input is a registered level.
*/
`timescale 1ns/10ps
module lowvolt_delay #(
  parameter int DELAY_CYC = irq_pkg::LV_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Status level and request pulse
  input wire logic status_i,
  output logic req_o
);

  localparam int CNT_W = $clog2(DELAY_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DELAY_CYC - 1);

  typedef struct packed {
    irq_pkg::lv_delay_state_t fsm;
    logic [CNT_W-1:0] cnt;
  } dly_state_t;

  dly_state_t st_reg;
  dly_state_t st_next;

  // A status dip restarts the wait, so a brief toggle near the
  // threshold never raises a request on its own.
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.fsm)
      irq_pkg::LV_WAIT: begin
        st_next.cnt = '0;
        if (status_i) begin
          st_next.fsm = irq_pkg::LV_COUNT;
        end
      end
      irq_pkg::LV_COUNT: begin
        if (!status_i) begin
          st_next.fsm = irq_pkg::LV_WAIT;
        end else if (st_reg.cnt == CNT_LAST) begin
          st_next.fsm = irq_pkg::LV_FIRED;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      irq_pkg::LV_FIRED: begin
        if (!status_i) begin
          st_next.fsm = irq_pkg::LV_WAIT;
        end
      end
      default: begin
        st_next.fsm = irq_pkg::LV_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign req_o = (st_reg.fsm == irq_pkg::LV_COUNT) && status_i &&
                 (st_reg.cnt == CNT_LAST);

  // Helper: consecutive cycles the status has stood high.
  logic [CNT_W:0] high_run;
  always_ff @(posedge clk_i) begin
    if (reset_i || !status_i) begin
      high_run <= '0;
    end else if (high_run <= (CNT_W+1)'(DELAY_CYC)) begin
      high_run <= high_run + 1'b1;
    end
  end

  req_after_delay_a: assert property (@(posedge clk_i) disable iff (reset_i)
    req_o |-> high_run == (CNT_W+1)'(DELAY_CYC))
    else $error("Low-voltage request not exactly one delay after rise.");

endmodule : lowvolt_delay

// [irq_ctrl.sv]
/*
  Interrupt request logic with edge-selected external pins, primary and
  multi-function request/enable registers, and the low-voltage detector
  source with its wake-up. Assumes the core drives the register port
  synchronously and services irq_o; the analog comparator supplies a
  synchronous below-threshold level for the selected threshold.
*/
`timescale 1ns/10ps
module irq_ctrl #(
  parameter int LV_DELAY_CYC = irq_pkg::LV_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [irq_pkg::REG_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Event sources and pins
  input wire irq_pkg::periph_evt_t periph_evt_i,
  input wire logic ext_irq_pin_a_i,
  input wire logic ext_irq_pin_b_i,
  input wire logic serial_wake_i,
  // Power state and analog detector
  input wire logic power_down_i,
  input wire logic supply_below_i,
  output logic lvd_enable_o,
  output logic lvd_ref_en_o,
  output logic [2:0] lowvolt_threshold_o,
  // Core side
  output logic irq_o,
  output logic wake_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [irq_pkg::REG_COUNT-1:0][7:0] regs;
    logic irq;
    logic wake;
    logic [7:0] rdata;
  } ctrl_state_t;

  ctrl_state_t st_reg;
  ctrl_state_t st_next;

  logic [irq_pkg::REG_COUNT-1:0][7:0] set_vec;
  logic [2:0] mf_set;
  logic [1:0] pin_hit;
  logic [1:0] pins;
  logic lv_pulse;
  logic supply_low_status;
  logic lowvolt_detector_on;
  logic lowvolt_req_flag;
  logic global_irq_en;
  logic serial_port_irq_en;
  logic [7:0] ctrl_a;
  logic [7:0] ctrl_b;
  logic [7:0] ctrl_c;
  logic [7:0] grp_c;

  assign ctrl_a = st_reg.regs[irq_pkg::IDX_CTRL_A];
  assign ctrl_b = st_reg.regs[irq_pkg::IDX_CTRL_B];
  assign ctrl_c = st_reg.regs[irq_pkg::IDX_CTRL_C];
  assign grp_c = st_reg.regs[irq_pkg::IDX_GRP_C];
  assign supply_low_status =
    st_reg.regs[irq_pkg::IDX_LVD][irq_pkg::LVD_STATUS];
  assign lowvolt_detector_on =
    st_reg.regs[irq_pkg::IDX_LVD][irq_pkg::LVD_ON];
  assign lowvolt_req_flag = grp_c[irq_pkg::GC_LV];
  assign global_irq_en = ctrl_a[irq_pkg::CA_GLOBAL_EN];
  assign serial_port_irq_en = ctrl_c[irq_pkg::CC_UART_EN];
  assign pins = {ext_irq_pin_b_i, ext_irq_pin_a_i};

  // ---------------------------------------------------------------
  // External pin edge detection
  // ---------------------------------------------------------------
  // Pin a uses edge field bits 1..0, pin b bits 3..2.
  for (genvar p = 0; p < 2; p++) begin : g_pin
    pin_edge_detect u_edge (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .pin_i(pins[p]),
      .edge_sel_i(st_reg.regs[irq_pkg::IDX_EDGE][p*2 +: 2]),
      .hit_o(pin_hit[p])
    );
  end

  // ---------------------------------------------------------------
  // Low-voltage request delay
  // ---------------------------------------------------------------
  // The detector keeps running whether or not the core is powered
  // down; only the detector-on bit stops it.
  lowvolt_delay #(
    .DELAY_CYC(LV_DELAY_CYC)
  ) u_lv_delay (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .status_i(supply_low_status),
    .req_o(lv_pulse)
  );

  // ---------------------------------------------------------------
  // Hardware set events
  // ---------------------------------------------------------------
  // Each multi-function flag collects its enabled sub-requests.
  always_comb begin
    set_vec = '0;
    for (int g = 0; g < 3; g++) begin
      mf_set[g] = |(st_reg.regs[irq_pkg::IDX_GRP_A + g]
                    [irq_pkg::GRP_FLAG_HI:irq_pkg::GRP_FLAG_LO] &
                    st_reg.regs[irq_pkg::IDX_GRP_A + g]
                    [irq_pkg::GRP_EN_HI:irq_pkg::GRP_EN_LO]);
    end
    set_vec[irq_pkg::IDX_CTRL_A][irq_pkg::CA_MF0_FLAG] = mf_set[0];
    set_vec[irq_pkg::IDX_CTRL_A][irq_pkg::CA_PA_FLAG] = pin_hit[0];
    set_vec[irq_pkg::IDX_CTRL_B][irq_pkg::CB_TB0] = periph_evt_i.time_base0;
    set_vec[irq_pkg::IDX_CTRL_B][irq_pkg::CB_ADC] = periph_evt_i.adc_done;
    set_vec[irq_pkg::IDX_CTRL_B][irq_pkg::CB_MF2] = mf_set[2];
    set_vec[irq_pkg::IDX_CTRL_B][irq_pkg::CB_MF1] = mf_set[1];
    set_vec[irq_pkg::IDX_CTRL_C][irq_pkg::CC_UART] = periph_evt_i.uart_event;
    set_vec[irq_pkg::IDX_CTRL_C][irq_pkg::CC_SIM] = periph_evt_i.sim_event;
    set_vec[irq_pkg::IDX_CTRL_C][irq_pkg::CC_PB] = pin_hit[1];
    set_vec[irq_pkg::IDX_CTRL_C][irq_pkg::CC_TB1] = periph_evt_i.time_base1;
    set_vec[irq_pkg::IDX_GRP_A][irq_pkg::GRP_MATCH_A] =
      periph_evt_i.tm0_match_a;
    set_vec[irq_pkg::IDX_GRP_A][irq_pkg::GRP_MATCH_P] =
      periph_evt_i.tm0_match_p;
    set_vec[irq_pkg::IDX_GRP_B][irq_pkg::GRP_MATCH_A] =
      periph_evt_i.tm1_match_a;
    set_vec[irq_pkg::IDX_GRP_B][irq_pkg::GRP_MATCH_P] =
      periph_evt_i.tm1_match_p;
    set_vec[irq_pkg::IDX_GRP_C][irq_pkg::GC_EEPROM] =
      periph_evt_i.eeprom_done;
    set_vec[irq_pkg::IDX_GRP_C][irq_pkg::GC_LV] = lv_pulse;
  end

  // ---------------------------------------------------------------
  // Register file, request output and wake-up
  // ---------------------------------------------------------------
  // A software write and a hardware set in the same cycle merge with
  // the set winning, so no event is lost while a flag is being cleared.
  // Unmapped indices match no register, so writes to them are dropped
  // and reads of them return zero.
  always_comb begin
    logic [7:0] val;
    val = '0;
    st_next = st_reg;
    for (int r = 0; r < irq_pkg::REG_COUNT; r++) begin
      val = (wr_i && addr_i == irq_pkg::REG_ADDR_W'(r)) ?
            wdata_i : st_reg.regs[r];
      st_next.regs[r] = (val | set_vec[r]) & irq_pkg::IMPL_MASK[r];
    end
    // The status bit is not writable; it tracks the comparator only
    // while the detector is switched on.
    st_next.regs[irq_pkg::IDX_LVD][irq_pkg::LVD_STATUS] =
      lowvolt_detector_on & supply_below_i;
    // Request to the core: flag and enable of one source, plus global.
    // There is no acknowledge, so the request stands until software
    // clears the flag or one of the enables.
    st_next.irq = global_irq_en &
      ((ctrl_a[irq_pkg::CA_MF0_FLAG] & ctrl_a[irq_pkg::CA_MF0_EN]) |
       (ctrl_a[irq_pkg::CA_PA_FLAG] & ctrl_a[irq_pkg::CA_PA_EN]) |
       (|(ctrl_b[irq_pkg::PAIR_FLAG_HI:irq_pkg::PAIR_FLAG_LO] &
          ctrl_b[irq_pkg::PAIR_EN_HI:irq_pkg::PAIR_EN_LO])) |
       (|(ctrl_c[irq_pkg::PAIR_FLAG_HI:irq_pkg::PAIR_FLAG_LO] &
          ctrl_c[irq_pkg::PAIR_EN_HI:irq_pkg::PAIR_EN_LO])));
    // Only a fresh low-voltage flag wakes; a flag preset by software
    // before power-down therefore suppresses the wake-up. A serial wake
    // wakes whenever the core is powered down but sets no request flag by itself.
    st_next.wake = power_down_i &
      ((lv_pulse & ~lowvolt_req_flag) | serial_wake_i);
    // Read data stand only in the cycle after the strobe.
    st_next.rdata = '0;
    if (rd_i && addr_i < irq_pkg::REG_ADDR_W'(irq_pkg::REG_COUNT)) begin
      st_next.rdata = st_reg.regs[addr_i[$clog2(irq_pkg::REG_COUNT)-1:0]];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops; the reference follows the
  // detector-on bit with no control of its own.
  assign rdata_o = st_reg.rdata;
  assign irq_o = st_reg.irq;
  assign wake_o = st_reg.wake;
  assign lvd_enable_o = lowvolt_detector_on;
  assign lvd_ref_en_o = lowvolt_detector_on;
  assign lowvolt_threshold_o =
    st_reg.regs[irq_pkg::IDX_LVD][irq_pkg::LVD_THR_HI:irq_pkg::LVD_THR_LO];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence pin_a_armed_s;
    global_irq_en && ctrl_a[irq_pkg::CA_PA_FLAG] &&
    ctrl_a[irq_pkg::CA_PA_EN];
  endsequence

  sequence lv_sub_armed_s;
    grp_c[irq_pkg::GC_LV] && grp_c[irq_pkg::GRP_EN_LO];
  endsequence

  irq_needs_global_a: assert property (
    irq_o |-> $past(global_irq_en))
    else $error("Interrupt presented without global enable.");

  irq_from_source_a: assert property (
    pin_a_armed_s |=> irq_o)
    else $error("Armed pin request did not reach the core.");

  pin_flag_set_a: assert property (
    pin_hit[0] |=> ctrl_a[irq_pkg::CA_PA_FLAG])
    else $error("Pin edge did not set its request flag.");

  set_wins_a: assert property (
    (wr_i && addr_i == irq_pkg::IDX_CTRL_C && pin_hit[1])
    |=> ctrl_c[irq_pkg::CC_PB])
    else $error("Pin request lost against a software clear.");

  status_track_a: assert property (
    !lowvolt_detector_on |=> !supply_low_status)
    else $error("Status high with detector switched off.");

  status_low_a: assert property (
    (lowvolt_detector_on && supply_below_i) |=> supply_low_status)
    else $error("Supply below threshold but status low.");

  lv_chain_a: assert property (
    lv_sub_armed_s |=> ctrl_b[irq_pkg::CB_MF2] ##1
    (irq_o || !$past(global_irq_en && ctrl_b[irq_pkg::PAIR_EN_LO+1])))
    else $error("Low-voltage sub-request not collected into group flag.");

  lv_wake_a: assert property (
    (power_down_i && lv_pulse && !lowvolt_req_flag) |=>
    wake_o && lowvolt_req_flag)
    else $error("Fresh low-voltage flag did not wake the device.");

  serial_wake_a: assert property (
    (power_down_i && serial_wake_i) |=> wake_o)
    else $error("Serial wake event did not wake the device.");

  read_reserved_a: assert property (
    (rd_i && addr_i == irq_pkg::IDX_EDGE) |=> rdata_o[7:4] == 4'h0)
    else $error("Unimplemented edge-select bits read nonzero.");

  // Without both enables a serial wake leaves the serial flag alone.
  serial_no_irq_a: assert property (
    (power_down_i && serial_wake_i &&
     !(global_irq_en && serial_port_irq_en) &&
     !periph_evt_i.uart_event && !ctrl_c[irq_pkg::CC_UART] &&
     !(wr_i && addr_i == irq_pkg::IDX_CTRL_C)) |=>
    !ctrl_c[irq_pkg::CC_UART])
    else $error("Serial wake set a request with its enables clear.");

  // A flag preset before power-down must keep the core asleep.
  lv_no_wake_a: assert property (
    (power_down_i && lv_pulse && lowvolt_req_flag && !serial_wake_i)
    |=> !wake_o)
    else $error("Preset low-voltage flag still woke the device.");

  // Every wake has a cause seen while the core was powered down.
  wake_cause_a: assert property (
    wake_o |-> $past(power_down_i))
    else $error("Wake raised while the core was running.");

  irq_off_global_a: assert property (
    !global_irq_en |=> !irq_o)
    else $error("Interrupt raised with global enable clear.");

  pin_b_flag_a: assert property (
    pin_hit[1] |=> ctrl_c[irq_pkg::CC_PB])
    else $error("Second pin edge did not set its request flag.");

  // ---------------------------------------------------------------
  // Register port assertions
  // ---------------------------------------------------------------
  // Read data must fall back to zero once the read cycle is over.
  rdata_idle_a: assert property (
    !rd_i |=> rdata_o == 8'h00)
    else $error("Read data stood longer than one cycle.");

  // Software cannot force the status bit high by writing it.
  status_no_write_a: assert property (
    (wr_i && addr_i == irq_pkg::IDX_LVD && !supply_below_i) |=>
    !supply_low_status)
    else $error("Status bit followed a software write.");

endmodule : irq_ctrl

// [cpu_core_model.sv]
/*
  Behavioural CPU core on the far side of the interrupt controller: it
  sleeps on request, wakes on the wake line and counts the interrupts
  it accepts. Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module cpu_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Controller side and sleep request
  input wire logic irq_i,
  input wire logic wake_i,
  input wire logic sleep_req_i,
  // Core state
  output logic power_down_o,
  output logic [7:0] taken_count_o
);
  // ------------------------------------------------------------
  // Sleep state and interrupt acceptance
  // ------------------------------------------------------------
  logic irq_seen;

  // A wake beats a sleep request in the same cycle, so none is lost.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      power_down_o <= 1'b0;
      taken_count_o <= 8'h00;
      irq_seen <= 1'b0;
    end else begin
      if (wake_i) begin
        power_down_o <= 1'b0;
      end else if (sleep_req_i) begin
        power_down_o <= 1'b1;
      end
      irq_seen <= irq_i;
      if (irq_i && !irq_seen) begin
        taken_count_o <= taken_count_o + 8'h01;
      end
    end
  end
endmodule : cpu_core_model

// [tb_irq_ctrl.sv]
/*
  Self-checking bench for irq_ctrl with the core model on its far side.
  Assumes the package, the design files and the core model come first.
*/
`timescale 1ns/10ps
module tb_irq_ctrl;
  // ------------------------------------------------------------
  // Signals, tables and instances
  // ------------------------------------------------------------
  localparam int DLY = 4;
  localparam logic [2:0][9:0] EV = {10'h020, 10'h040, 10'h200};
  localparam logic [2:0][3:0] GA = {4'h6, 4'h5, 4'h4};
  localparam logic [2:0][7:0] FL = {8'h20, 8'h10, 8'h20};
  localparam logic [2:0][3:0] CA = {4'h2, 4'h2, 4'h1};
  localparam logic [2:0][7:0] MF = {8'h20, 8'h10, 8'h40};
  // Register and flag that each event bit sets, event bit 9 first.
  localparam logic [9:0][3:0] EV_IDX = {4'h4, 4'h4, 4'h5, 4'h5, 4'h6,
    4'h2, 4'h3, 4'h2, 4'h3, 4'h3};
  localparam logic [9:0][7:0] EV_VAL = {8'h20, 8'h10, 8'h20, 8'h10,
    8'h20, 8'h80, 8'h10, 8'h40, 8'h40, 8'h80};
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] w;
    logic [7:0] r;
  } row_t;
  localparam row_t [8:0] ROWS = {{4'h9, 8'hFF, 8'h00},
    {4'h7, 8'hFF, 8'h17}, {4'h6, 8'hFF, 8'h33}, {4'h5, 8'h03, 8'h03},
    {4'h4, 8'hFC, 8'h30}, {4'h3, 8'h55, 8'h55}, {4'h2, 8'hAA, 8'hAA},
    {4'h1, 8'h5A, 8'h5A}, {4'h0, 8'hFF, 8'h0F}};
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [irq_pkg::REG_ADDR_W-1:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  irq_pkg::periph_evt_t periph_evt_i = '0;
  logic ext_irq_pin_a_i = 1'b0;
  logic ext_irq_pin_b_i = 1'b0;
  logic serial_wake_i = 1'b0;
  logic supply_below_i = 1'b0;
  logic sleep_req = 1'b0;
  logic power_down_i, lvd_enable_o, lvd_ref_en_o, irq_o, wake_o;
  logic [2:0] lowvolt_threshold_o;
  logic [7:0] taken_count;
  int num_errors = 0;
  int total_checks = 0;

  // Free-running 50 MHz system clock.
  always #10 clk_i = ~clk_i;

  irq_ctrl #(.LV_DELAY_CYC(DLY)) irq_ctrl_inst (.clk_i(clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .periph_evt_i(periph_evt_i),
    .ext_irq_pin_a_i(ext_irq_pin_a_i), .ext_irq_pin_b_i(ext_irq_pin_b_i),
    .serial_wake_i(serial_wake_i), .power_down_i(power_down_i),
    .supply_below_i(supply_below_i), .lvd_enable_o(lvd_enable_o),
    .lvd_ref_en_o(lvd_ref_en_o), .lowvolt_threshold_o(lowvolt_threshold_o),
    .irq_o(irq_o), .wake_o(wake_o));
  cpu_core_model cpu_core_model_inst (.clk_i(clk_i), .reset_i(reset_i),
    .irq_i(irq_o), .wake_i(wake_o), .sleep_req_i(sleep_req),
    .power_down_o(power_down_i), .taken_count_o(taken_count));

  // ------------------------------------------------------------
  // Compare, bus and wait tasks
  // ------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t byte got %h exp %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t bit got %b exp %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so look there.
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check_byte(rdata_o, exp);
  endtask : rd_chk

  task automatic set_pin(input int p, input logic v);
    @(posedge clk_i);
    if (p == 0) begin
      ext_irq_pin_a_i <= v;
    end else begin
      ext_irq_pin_b_i <= v;
    end
  endtask : set_pin

  task automatic do_reset();
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    cyc(1);
    check_bit(irq_o, 1'b0);
    check_bit(wake_o, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rd_chk(4'(i), irq_pkg::REG_RESET);
    end
  endtask : do_reset

  // Grouping registers go before the control registers, since a still-set sub-request would
  // set its multi-function flag again.
  task automatic clear_all();
    for (int i = 7; i >= 0; i--) begin
      wr(4'(i), 8'h00);
    end
  endtask : clear_all

  // The bound only runs out by design where no wake is expected.
  task automatic wait_wake(input logic exp);
    int n;
    n = 0;
    while (power_down_i === 1'b1 && n < 30) begin
      cyc(1);
      n++;
    end
    check_bit(!power_down_i, exp);
    if (exp && n >= 30) begin
      summarize();
    end
  endtask : wait_wake

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [3:0] ca;
    logic [7:0] fb;
    int g;
    do_reset();
    for (int i = 0; i < 9; i++) begin
      wr(ROWS[i].a, ROWS[i].w);
      rd_chk(ROWS[i].a, ROWS[i].r);
    end
    // Armed sources in the second and third registers need the global.
    check_bit(irq_o, 1'b0);
    wr(irq_pkg::IDX_CTRL_A, 8'h01);
    cyc(2);
    check_bit(irq_o, 1'b1);
    clear_all();
    // Every edge mode on both pins, rising then falling.
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 4; s++) begin
        ca = (p == 1) ? irq_pkg::IDX_CTRL_C : irq_pkg::IDX_CTRL_A;
        fb = (p == 1) ? 8'h20 : 8'h10;
        wr(irq_pkg::IDX_EDGE, (p == 1) ? 8'(s << 2) : 8'(s));
        set_pin(p, 1'b1);
        cyc(2);
        rd_chk(ca, s[0] ? fb : 8'h00);
        wr(ca, 8'h00);
        set_pin(p, 1'b0);
        cyc(2);
        rd_chk(ca, s[1] ? fb : 8'h00);
        wr(ca, 8'h00);
      end
    end
    // A pin edge that meets a software clear of its flag must win.
    @(posedge clk_i);
    addr_i <= irq_pkg::IDX_CTRL_C;
    wdata_i <= 8'h00;
    wr_i <= 1'b1;
    ext_irq_pin_b_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_chk(irq_pkg::IDX_CTRL_C, 8'h20);
    // Flag, own enable and global enable in all combinations.
    for (int i = 0; i < 8; i++) begin
      wr(irq_pkg::IDX_CTRL_A, {3'h0, i[2], 2'h0, i[1], i[0]});
      cyc(2);
      check_bit(irq_o, i == 7);
    end
    clear_all();
    // Each event pulse alone sets its own flag and no other.
    for (int b = 0; b < 10; b++) begin
      @(posedge clk_i);
      periph_evt_i <= irq_pkg::periph_evt_t'(10'h001 << b);
      @(posedge clk_i);
      periph_evt_i <= '0;
      rd_chk(EV_IDX[b], EV_VAL[b]);
      wr(EV_IDX[b], 8'h00);
    end
    // Sub-requests with and without their enables.
    for (int k = 0; k < 6; k++) begin
      g = k % 3;
      wr(GA[g], (k < 3) ? FL[g] >> 4 : 8'h00);
      @(posedge clk_i);
      periph_evt_i <= irq_pkg::periph_evt_t'(EV[g]);
      @(posedge clk_i);
      periph_evt_i <= '0;
      cyc(3);
      rd_chk(GA[g], ((k < 3) ? FL[g] >> 4 : 8'h00) | FL[g]);
      rd_chk(CA[g], (k < 3) ? MF[g] : 8'h00);
      clear_all();
    end
    wr(irq_pkg::IDX_GRP_C, 8'h01);
    wr(irq_pkg::IDX_LVD, 8'h13);
    cyc(1);
    check_bit(lvd_enable_o, 1'b1);
    check_bit(lvd_ref_en_o, 1'b1);
    check_byte({5'h00, lowvolt_threshold_o}, 8'h03);
    cyc(4);
    rd_chk(irq_pkg::IDX_LVD, 8'h13);
    @(posedge clk_i);
    supply_below_i <= 1'b1;
    cyc(2);
    rd_chk(irq_pkg::IDX_GRP_C, 8'h01);
    cyc(DLY + 4);
    rd_chk(irq_pkg::IDX_GRP_C, 8'h11);
    rd_chk(irq_pkg::IDX_LVD, 8'h33);
    rd_chk(irq_pkg::IDX_CTRL_B, 8'h20);
    // A supply dip restarts detection, then a fresh low wakes the core.
    @(posedge clk_i);
    supply_below_i <= 1'b0;
    cyc(3);
    wr(irq_pkg::IDX_GRP_C, 8'h01);
    @(posedge clk_i);
    sleep_req <= 1'b1;
    @(posedge clk_i);
    sleep_req <= 1'b0;
    @(posedge clk_i);
    supply_below_i <= 1'b1;
    wait_wake(1'b1);
    @(posedge clk_i);
    supply_below_i <= 1'b0;
    cyc(3);
    wr(irq_pkg::IDX_GRP_C, 8'h10);
    @(posedge clk_i);
    sleep_req <= 1'b1;
    @(posedge clk_i);
    sleep_req <= 1'b0;
    @(posedge clk_i);
    supply_below_i <= 1'b1;
    wait_wake(1'b0);
    wr(irq_pkg::IDX_CTRL_A, 8'h01);
    @(posedge clk_i);
    serial_wake_i <= 1'b1;
    @(posedge clk_i);
    serial_wake_i <= 1'b0;
    wait_wake(1'b1);
    rd_chk(irq_pkg::IDX_CTRL_C, 8'h00);
    check_bit(irq_o, 1'b0);
    wr(irq_pkg::IDX_LVD, 8'h03);
    cyc(1);
    check_bit(lvd_enable_o, 1'b0);
    check_bit(lvd_ref_en_o, 1'b0);
    rd_chk(irq_pkg::IDX_LVD, 8'h03);
    check_byte(taken_count, 8'h02);
    do_reset();
    summarize();
  end
endmodule : tb_irq_ctrl
